// [bench/clpd_link_partner.sv]
// link partner model: echoes detect pulses, shows energy and link
`timescale 1ns/1ps
module clpd_link_partner
(
    input wire ref_clk,
    input wire rst,
    input wire flp_detect_tx,
    input wire aneg_run,
    input wire powered_down,
    input wire plugged,
    input wire link_ok,
    output reg energy_detect,
    output reg flp_loopback,
    output reg link_up
);
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            energy_detect <= 1'b0;
            flp_loopback <= 1'b0;
            link_up <= 1'b0;
        end
        else
        begin
            // echo only while pulses are really sent, never a stuck level
            flp_loopback <= powered_down & flp_detect_tx;
            energy_detect <= plugged;
            // no link without autonegotiation running on our side
            link_up <= aneg_run & link_ok;
        end
    end
endmodule

// [bench/clpd_properties.sv]
// port assertions for the power controller
`timescale 1ns/1ps
module clpd_props
(
    input wire ref_clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire energy_detect,
    input wire flp_loopback,
    input wire flp_detect_tx,
    input wire aneg_run,
    input wire low_power,
    input wire wake_burst,
    input wire management_interrupt_pin
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    det_code_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h2 |-> reg_rdata[1:0] != 2'h3)
        else $error("detect status reads 11");
    search_excl_a: assert property (!(flp_detect_tx && aneg_run))
        else $error("detect pulses during autonegotiation");
    irq_rise_a: assert property ($rose(management_interrupt_pin) |-> $past(flp_loopback, 2))
        else $error("interrupt without loopback");
    irq_fall_a: assert property ($fell(management_interrupt_pin) |-> $past(reg_rd, 2) && $past(reg_addr, 2) == 4'h3)
        else $error("interrupt dropped without read");
    burst_pulse_a: assert property (wake_burst |=> !wake_burst [*8])
        else $error("burst pulse too long");
    burst_wake_a: assert property (wake_burst |-> ##[0:1] !low_power)
        else $error("burst in low power");
    energy_wake_a: assert property (low_power && energy_detect |-> ##[1:2] !low_power)
        else $error("energy ignored in low power");

    cover property (wake_burst);
    cover property ($rose(management_interrupt_pin));
    cover property ($fell(low_power));
endmodule

// [bench/tb_top.sv]
// self-checking bench for the power controller
`timescale 1ns/1ps
`include "clpd_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic ref_clk, rst, reg_wr, reg_rd, powered_down, plugged, link_ok;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    wire [15:0] reg_rdata;
    wire energy_detect, flp_loopback, link_up, flp_detect_tx, aneg_run, low_power, wake_burst, wake_pair_b;
    wire management_interrupt_pin;
    int err_count = 0;
    int tests_run = 0;
    int n;
    logic p0, p1;

    clpd_power_ctl #(.MS_CYCLES(10), .DET_LIMIT_MS(3)) u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .energy_detect(energy_detect), .flp_loopback(flp_loopback), .link_up(link_up),
        .flp_detect_tx(flp_detect_tx), .aneg_run(aneg_run), .low_power(low_power), .wake_burst(wake_burst),
        .wake_pair_b(wake_pair_b), .management_interrupt_pin(management_interrupt_pin));
    clpd_link_partner u_lp (.ref_clk(ref_clk), .rst(rst), .flp_detect_tx(flp_detect_tx), .aneg_run(aneg_run),
        .powered_down(powered_down), .plugged(plugged), .link_ok(link_ok), .energy_detect(energy_detect),
        .flp_loopback(flp_loopback), .link_up(link_up));

    always #5 ref_clk = ~ref_clk;

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // sel 0 interrupt pin, 1 low power, 2 burst; returns cycles waited
    task automatic wait_on(input int sel, input logic v, input int lim, output int k);
        k = 0;
        while (((sel == 0) ? management_interrupt_pin : (sel == 1) ? low_power : wake_burst) !== v && k < lim)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        if (k >= lim)
        begin
            err_count++;
            $display("MISMATCH t=%0t wait %h level %h", $time, sel, v);
            results();
        end
    endtask

    initial
    begin
        ref_clk = 0;
        rst = 1;
        {reg_wr, reg_rd, powered_down, plugged, link_ok} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK(low_power, 1'b1)
        chk_rd(4'h0, 16'h0001);
        chk_rd(4'h1, `CLPD_TMR_RESET);
        wr(4'h7, 16'hFFFF);
        chk_rd(4'h7, 16'h0000);
        wr(4'h2, 16'hFFFF);
        wr(4'h0, 16'h0003);
        repeat (3) @(posedge ref_clk);
        chk_rd(4'h2, 16'h0020);
        `CHK(flp_detect_tx, 1'b1)
        powered_down <= 1'b1;
        wait_on(0, 1'b1, 20, n);
        powered_down <= 1'b0;
        chk_rd(4'h2, 16'h0021);
        chk_rd(4'h3, 16'h0001);
        chk_rd(4'h3, 16'h0000);
        `CHK(management_interrupt_pin, 1'b0)
        repeat (60) @(posedge ref_clk);
        chk_rd(4'h2, 16'h0022);
        `CHK({aneg_run, flp_detect_tx}, 2'b10)
        link_ok <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_rd(4'h2, 16'h0026);
        link_ok <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_rd(4'h2, 16'h0020);
        `CHK({aneg_run, flp_detect_tx}, 2'b01)
        // host pulls power after the failure, so the partner loops pulses again
        powered_down <= 1'b1;
        wait_on(0, 1'b1, 20, n);
        powered_down <= 1'b0;
        chk_rd(4'h2, 16'h0021);
        chk_rd(4'h3, 16'h0001);
        // shortest timers keep the power walk inside the run budget
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h0005);
        wait_on(1, 1'b1, 10200, n);
        wait_on(2, 1'b1, 10700, n);
        `CHK(n >= 9150, 1'b1)
        `CHK(n <= 10610, 1'b1)
        p0 = wake_pair_b;
        wait_on(2, 1'b0, 3, n);
        wait_on(2, 1'b1, 200, n);
        p1 = wake_pair_b;
        `CHK(p1, ~p0)
        wait_on(2, 1'b0, 3, n);
        wait_on(2, 1'b1, 200, n);
        `CHK(wake_pair_b, ~p1)
        wait_on(1, 1'b1, 1400, n);
        plugged <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK(low_power, 1'b0)
        wr(4'h0, 16'h0004);
        plugged <= 1'b0;
        repeat (10500) @(posedge ref_clk);
        #1;
        `CHK(low_power, 1'b0)
        results();
    end
endmodule

bind clpd_power_ctl clpd_props u_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .energy_detect(energy_detect), .flp_loopback(flp_loopback),
    .flp_detect_tx(flp_detect_tx), .aneg_run(aneg_run), .low_power(low_power), .wake_burst(wake_burst),
    .management_interrupt_pin(management_interrupt_pin));

// [src/clpd_consts.vh]
// constants for the copper link power detect and power management block
//Contract
//- detection enable bit starts inline-power detection; here it starts only with the autonegotiation enable bit also set
//- searching sends special pulses, status 00
//- looped-back pulses set status 01
//- loopback sets interrupt bit; read clears it
//- no loopback within limit sets status 10
//- status 10 starts autonegotiation, link sets status
//- link failure re-enables detection, stops autonegotiation
//- power management enable bit, settable any time
//- alternate low power and wake, energy→normal
//- normal: link drop, timeout, then low power
//- power management starts in low power; enabling it here leaves the port normal until the link timeout
//- forced mode stays normal once energy seen
//- autonegotiation off in normal keeps normal
//- management and interrupt stay alive; energy monitored
//- sleep time programmable, randomized -80..+60 ms
//- wake sends up to three bursts, alternating pairs
`ifndef CLPD_CONSTS_VH
`define CLPD_CONSTS_VH

// register addresses
`define CLPD_ADDR_CTRL 4'h0
`define CLPD_ADDR_TIMER 4'h1
`define CLPD_ADDR_STATUS 4'h2
`define CLPD_ADDR_INT 4'h3

// control register fields
`define CLPD_CTRL_ANEG_EN 0
`define CLPD_CTRL_DETECT_EN 1
`define CLPD_CTRL_PM_EN 2
`define CLPD_CTRL_RESET 16'h0001

// timer register fields: sleep select, wake select, link timeout select
`define CLPD_TMR_SLEEP_LO 0
`define CLPD_TMR_WAKE_LO 2
`define CLPD_TMR_LTO_LO 4
`define CLPD_TMR_RESET 16'h0001

// status register fields
`define CLPD_STS_DET_LO 0
`define CLPD_STS_LINK 2
`define CLPD_STS_LOW 3
`define CLPD_STS_WAKE 4
`define CLPD_STS_NORM 5

// interrupt register field
`define CLPD_INT_INLINE 0

// detection status codes
`define CLPD_DET_SEARCH 2'h0
`define CLPD_DET_FOUND 2'h1
`define CLPD_DET_DONE 2'h2

// timing, milliseconds unless noted
`define CLPD_CLK_MHZ 100
`define CLPD_TICK_US 1000
`define CLPD_SLEEP_MS_0 13'd1000
`define CLPD_SLEEP_MS_1 13'd2000
`define CLPD_SLEEP_MS_2 13'd3000
`define CLPD_SLEEP_MS_3 13'd4000
`define CLPD_WAKE_MS_0 13'd160
`define CLPD_WAKE_MS_1 13'd400
`define CLPD_WAKE_MS_2 13'd800
`define CLPD_WAKE_MS_3 13'd2000
`define CLPD_LTO_MS_0 13'd1000
`define CLPD_LTO_MS_1 13'd2000
`define CLPD_LTO_MS_2 13'd3000
`define CLPD_LTO_MS_3 13'd4000
`define CLPD_DET_LIMIT_MS 13'd50
`define CLPD_BURST_GAP_MS 13'd16
`define CLPD_BURST_MAX 2'd3
`define CLPD_RAND_NEG 13'd80
`define CLPD_RAND_SPAN 16'd141

`endif

// [src/clpd_power_ctl.v]
// per-port inline-power detection and automatic power management controller
`timescale 1ns/1ps
`include "clpd_consts.vh"

module clpd_power_ctl
#(
    parameter MS_CYCLES = `CLPD_TICK_US * `CLPD_CLK_MHZ,
    parameter DET_LIMIT_MS = `CLPD_DET_LIMIT_MS
)
(
    input wire ref_clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire energy_detect,
    input wire flp_loopback,
    input wire link_up,
    output reg flp_detect_tx,
    output reg aneg_run,
    output reg low_power,
    output reg wake_burst,
    output reg wake_pair_b,
    output reg management_interrupt_pin
);

    localparam DET_IDLE = 3'b001;
    localparam DET_SRCH = 3'b010;
    localparam DET_AN = 3'b100;
    localparam PM_LOW = 3'b001;
    localparam PM_WAKE = 3'b010;
    localparam PM_NORM = 3'b100;

    // picks one of four millisecond figures
    function [12:0] pick4;
        input [1:0] sel;
        input [12:0] v0;
        input [12:0] v1;
        input [12:0] v2;
        input [12:0] v3;
        begin
            case (sel)
                2'h0: pick4 = v0;
                2'h1: pick4 = v1;
                2'h2: pick4 = v2;
                default: pick4 = v3;
            endcase
        end
    endfunction

    reg [15:0] ctrl;
    reg [15:0] timer_sel;
    reg inline_int;
    reg [2:0] det_state;
    reg [1:0] det_status;
    reg [12:0] det_ms;
    reg link_seen;
    reg [2:0] pm_state;
    reg [12:0] pm_ms;
    reg [1:0] burst_cnt;
    reg pair_b;
    reg [12:0] rand_off;
    reg [15:0] lfsr;
    reg [31:0] div_cnt;
    reg ms_tick;

    wire aneg_en = ctrl[`CLPD_CTRL_ANEG_EN];
    wire detect_en = ctrl[`CLPD_CTRL_DETECT_EN];
    wire pm_en = ctrl[`CLPD_CTRL_PM_EN];
    wire [1:0] sleep_sel = timer_sel[`CLPD_TMR_SLEEP_LO +: 2];
    wire [1:0] wake_sel = timer_sel[`CLPD_TMR_WAKE_LO +: 2];
    wire [1:0] lto_sel = timer_sel[`CLPD_TMR_LTO_LO +: 2];

    wire [12:0] sleep_ms = pick4(sleep_sel, `CLPD_SLEEP_MS_0, `CLPD_SLEEP_MS_1, `CLPD_SLEEP_MS_2,
        `CLPD_SLEEP_MS_3);
    wire [12:0] wake_ms = pick4(wake_sel, `CLPD_WAKE_MS_0, `CLPD_WAKE_MS_1, `CLPD_WAKE_MS_2, `CLPD_WAKE_MS_3);
    wire [12:0] lto_ms = pick4(lto_sel, `CLPD_LTO_MS_0, `CLPD_LTO_MS_1, `CLPD_LTO_MS_2, `CLPD_LTO_MS_3);
    // rand_off spans 0..140, so dwell spans sleep-80 .. sleep+60
    wire [12:0] dwell_ms = sleep_ms - `CLPD_RAND_NEG + rand_off;
    wire [15:0] rand_mod = lfsr % `CLPD_RAND_SPAN;

    wire det_hit = (det_state == DET_SRCH) && detect_en && flp_loopback;
    wire int_clear = reg_rd && (reg_addr == `CLPD_ADDR_INT);
    wire burst_due = (pm_state == PM_WAKE) && ms_tick && (burst_cnt < `CLPD_BURST_MAX)
        && (pm_ms == {11'd0, burst_cnt} * `CLPD_BURST_GAP_MS);

    // millisecond tick divider; everything slow runs on this enable
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt <= 32'h00000000;
            ms_tick <= 1'b0;
        end
        else if (div_cnt >= MS_CYCLES - 1)
        begin
            div_cnt <= 32'h00000000;
            ms_tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 32'h00000001;
            ms_tick <= 1'b0;
        end
    end

    // free-running generator, advances every clock
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            lfsr <= 16'hACE1;
        else
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    // register writes; bus stays alive in every power state
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `CLPD_CTRL_RESET;
            timer_sel <= `CLPD_TMR_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `CLPD_ADDR_CTRL)
                ctrl <= {13'd0, reg_wdata[2:0]};
            else if (reg_addr == `CLPD_ADDR_TIMER)
                timer_sel <= {10'd0, reg_wdata[5:0]};
        end
    end

    // register reads, data valid only in the following cycle
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `CLPD_ADDR_CTRL: reg_rdata <= ctrl;
                `CLPD_ADDR_TIMER: reg_rdata <= timer_sel;
                `CLPD_ADDR_STATUS: reg_rdata <= {10'd0, pm_state, link_up, det_status};
                `CLPD_ADDR_INT: reg_rdata <= {15'd0, inline_int};
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    // sticky inline-power flag; a new hit beats the read clear
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            inline_int <= 1'b0;
        else if (det_hit)
            inline_int <= 1'b1;
        else if (int_clear)
            inline_int <= 1'b0;
    end

    // detection sequence; status only ever takes 00, 01 or 10
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            det_state <= DET_IDLE;
            det_status <= `CLPD_DET_SEARCH;
            det_ms <= 13'd0;
            link_seen <= 1'b0;
        end
        else
        begin
            case (det_state)
                DET_IDLE:
                begin
                    if (detect_en && aneg_en)
                    begin
                        det_state <= DET_SRCH;
                        det_status <= `CLPD_DET_SEARCH;
                        det_ms <= 13'd0;
                    end
                end
                DET_SRCH:
                begin
                    if (!detect_en)
                        det_state <= DET_IDLE;
                    else if (flp_loopback)
                    begin
                        det_status <= `CLPD_DET_FOUND;
                        det_ms <= 13'd0;
                    end
                    else if (ms_tick)
                    begin
                        if (det_ms + 13'd1 >= DET_LIMIT_MS)
                        begin
                            det_status <= `CLPD_DET_DONE;
                            det_state <= DET_AN;
                            link_seen <= 1'b0;
                        end
                        else
                            det_ms <= det_ms + 13'd1;
                    end
                end
                DET_AN:
                begin
                    if (!detect_en)
                        det_state <= DET_IDLE;
                    else if (link_up)
                        link_seen <= 1'b1;
                    else if (link_seen)
                    begin
                        det_state <= DET_SRCH;
                        det_status <= `CLPD_DET_SEARCH;
                        det_ms <= 13'd0;
                    end
                end
                default:
                    det_state <= DET_IDLE;
            endcase
        end
    end

    // power management states; with the enable low the port just runs normal
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pm_state <= PM_LOW;
            pm_ms <= 13'd0;
            burst_cnt <= 2'd0;
            pair_b <= 1'b0;
            rand_off <= `CLPD_RAND_NEG;
        end
        else if (!pm_en)
        begin
            pm_state <= PM_NORM;
            pm_ms <= 13'd0;
        end
        else
        begin
            case (pm_state)
                PM_LOW:
                begin
                    if (energy_detect)
                    begin
                        pm_state <= PM_NORM;
                        pm_ms <= 13'd0;
                    end
                    else if (ms_tick)
                    begin
                        if (pm_ms + 13'd1 >= dwell_ms)
                        begin
                            pm_state <= PM_WAKE;
                            pm_ms <= 13'd0;
                            burst_cnt <= 2'd0;
                        end
                        else
                            pm_ms <= pm_ms + 13'd1;
                    end
                end
                PM_WAKE:
                begin
                    if (energy_detect)
                    begin
                        pm_state <= PM_NORM;
                        pm_ms <= 13'd0;
                    end
                    else if (ms_tick)
                    begin
                        if (burst_due)
                        begin
                            burst_cnt <= burst_cnt + 2'd1;
                            pair_b <= ~pair_b;
                        end
                        if (pm_ms + 13'd1 >= wake_ms)
                        begin
                            pm_state <= PM_LOW;
                            pm_ms <= 13'd0;
                            rand_off <= rand_mod[12:0];
                        end
                        else
                            pm_ms <= pm_ms + 13'd1;
                    end
                end
                PM_NORM:
                begin
                    // with autonegotiation off a dropped link never leads back to sleep
                    if (aneg_en && !link_up)
                    begin
                        if (ms_tick)
                        begin
                            if (pm_ms + 13'd1 >= lto_ms)
                            begin
                                pm_state <= PM_LOW;
                                pm_ms <= 13'd0;
                                rand_off <= rand_mod[12:0];
                            end
                            else
                                pm_ms <= pm_ms + 13'd1;
                        end
                    end
                    else
                        pm_ms <= 13'd0;
                end
                default:
                    pm_state <= PM_LOW;
            endcase
        end
    end

    // registered outputs, one cycle behind the state
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            flp_detect_tx <= 1'b0;
            aneg_run <= 1'b0;
            low_power <= 1'b0;
            wake_burst <= 1'b0;
            wake_pair_b <= 1'b0;
            management_interrupt_pin <= 1'b0;
        end
        else
        begin
            flp_detect_tx <= (det_state == DET_SRCH);
            aneg_run <= aneg_en && (det_state != DET_SRCH) && (pm_state == PM_NORM);
            low_power <= (pm_state == PM_LOW);
            // a burst due in the cycle that management drops the enable is not sent
            wake_burst <= burst_due && pm_en && !energy_detect;
            wake_pair_b <= pair_b;
            management_interrupt_pin <= inline_int;
        end
    end

endmodule
